// >>> include/hpsr_defs.vh
// register offsets, field positions, reset values and timing for the serial register bank
`ifndef HPSR_DEFS_VH
`define HPSR_DEFS_VH

`define HPSR_ADDR_LOW        7'h40
`define HPSR_ADDR_HIGH       7'h41

`define HPSR_IDX_VERSION     8'h00
`define HPSR_IDX_TRACK       8'h01
`define HPSR_IDX_DFLOOR      8'h02
`define HPSR_IDX_CCEIL       8'h03
`define HPSR_IDX_COLD        8'h04
`define HPSR_IDX_HOT         8'h05
`define HPSR_IDX_PWR         8'h06
`define HPSR_IDX_SLEEP       8'h07
`define HPSR_IDX_STORATE     8'h08
`define HPSR_IDX_PMON        8'h09
`define HPSR_IDX_INTERRUPT_ENABLES       8'h0a
`define HPSR_IDX_CTRL        8'h0b
`define HPSR_IDX_INTERRUPT_FLAGS      8'h0c
`define HPSR_IDX_STATUS      8'h0d
`define HPSR_IDX_PDATA0      8'h0e
`define HPSR_IDX_TEMPD       8'h11
`define HPSR_IDX_STOD        8'h12
`define HPSR_IDX_SRCD        8'h13
`define HPSR_IDX_LAST        8'h13

`define HPSR_RST_TRACK       8'h77
`define HPSR_RST_DFLOOR      8'h2d
`define HPSR_RST_CCEIL       8'h33
`define HPSR_RST_COLD        8'h8f
`define HPSR_RST_HOT         8'h2f
`define HPSR_RST_PWR         8'h07
`define HPSR_RST_SLEEP       8'h01
`define HPSR_RST_STORATE     8'h00
`define HPSR_RST_PMON        8'h00
`define HPSR_RST_INTERRUPT_ENABLES       8'h01

`define HPSR_MSK_TRACK       8'h7f
`define HPSR_MSK_THRESH      8'h3f
`define HPSR_MSK_PWR         8'h0f
`define HPSR_MSK_SLEEP       8'h0f
`define HPSR_MSK_STORATE     8'h07
`define HPSR_MSK_PMON        8'h0f
`define HPSR_MSK_IRQ         8'h3f
`define HPSR_MSK_STATUS      8'h5e

`define HPSR_PWR_HOLD        0
`define HPSR_PWR_CHGDIS      3
`define HPSR_CTRL_UPDATE     0
`define HPSR_CTRL_SYNC       2

// serial bus rates, in kHz, the slave must follow
`define HPSR_STD_KHZ         100
`define HPSR_FAST_KHZ        400
`define HPSR_FASTP_KHZ       1000

`endif

// >>> hdl/hpsr_sync2.v
// two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
module hpsr_sync2 (
  // clock and reset
  input  wire core_clk_in,
  input  wire nrst_in,
  // level
  input  wire async_in,
  input  wire rst_val_in,
  output wire sync_out
);
  reg meta_ff;
  reg sync_ff;

  // both flops reset to a fixed 1; the rst_val_in tie-off only gates the output while reset is low
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff & (nrst_in | rst_val_in);
endmodule

// >>> hdl/hpsr_serial_regs.v
// two-wire serial slave and register bank of the harvesting charger
`timescale 1ns/1ps
`include "hpsr_defs.vh"
module hpsr_serial_regs #(
  parameter [7:0] CHIP_VERSION = 8'h10  // arbitrary value
) (
  // clock and reset
  input  wire        core_clk_in,
  input  wire        nrst_in,
  input  wire        supply_ok_in,
  // serial bus pins
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out,
  output wire        sda_oe_n_out,
  // configuration pins
  input  wire        addr_sel_in,
  input  wire        charge_inhibit_pin_in,
  input  wire        supply_hold_pin_in,
  // measurement side
  input  wire [5:0]  event_in,
  input  wire [7:0]  status_in,
  input  wire        sync_pending_in,
  input  wire [23:0] power_data_in,
  input  wire [7:0]  temperature_in,
  input  wire [7:0]  storage_voltage_in,
  input  wire [7:0]  source_voltage_in,
  // effective controls
  output reg         charge_enable_out,
  output reg         supply_from_storage_out,
  output reg         irq_out,
  output reg  [7:0]  tracking_config_out,
  output reg  [5:0]  discharge_floor_out,
  output reg  [5:0]  charge_ceiling_out,
  output reg  [3:0]  power_settings_out,
  output reg         use_regs_out
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_ADDR = 6'h02;
  localparam [5:0] ST_AACK = 6'h04;
  localparam [5:0] ST_WRX  = 6'h08;
  localparam [5:0] ST_RTX  = 6'h10;
  localparam [5:0] ST_MACK = 6'h20;
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire [4:0] raw_pins;
  wire [4:0] sync_pins;
  wire [4:0] pin_rst;
  assign raw_pins = {supply_hold_pin_in, charge_inhibit_pin_in, addr_sel_in, sda_in, scl_in};
  assign pin_rst  = 5'h1f;
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
      hpsr_sync2 u_sync (
        .core_clk_in (core_clk_in),
        .nrst_in     (nrst_in),
        .async_in    (raw_pins[gi]),
        .rst_val_in  (pin_rst[gi]),
        .sync_out    (sync_pins[gi])
      );
    end
  endgenerate
  wire scl_s  = sync_pins[0];
  wire sda_s  = sync_pins[1];
  wire asel_s = sync_pins[2];
  wire inh_s  = sync_pins[3];
  wire hold_s = sync_pins[4];

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg  [7:0] track_ff;
  reg  [7:0] dfloor_ff;
  reg  [7:0] cceil_ff;
  reg  [7:0] cold_ff;
  reg  [7:0] hot_ff;
  reg  [7:0] pwr_ff;
  reg  [7:0] sleep_ff;
  reg  [7:0] storate_ff;
  reg  [7:0] pmon_ff;
  reg  [7:0] interrupt_enables_ff;
  reg        update_ff;
  reg  [5:0] flags_ff;
  reg        scl_d_ff;
  reg        sda_d_ff;
  reg  [5:0] state_ff;
  reg  [7:0] shift_ff;
  reg  [3:0] bitcnt_ff;
  reg  [7:0] index_ff;
  reg        first_ff;
  reg        rnw_ff;
  reg        drive_low_ff;
  reg        ack_hold_ff;

  // combined reset: pin reset or supply collapse
  wire rst_all = !nrst_in || !supply_ok_in;
  wire scl_rise = scl_s && !scl_d_ff;
  wire scl_fall = !scl_s && scl_d_ff;
  wire start_c  = scl_s && scl_d_ff && sda_d_ff && !sda_s;
  wire stop_c   = scl_s && scl_d_ff && !sda_d_ff && sda_s;
  // address select defaults high when pin floats
  wire [6:0] own_addr = asel_s ? `HPSR_ADDR_HIGH : `HPSR_ADDR_LOW;
  // ----------------------------------------
  // read mux
  // ----------------------------------------
  function [7:0] hpsr_rd;
    input [7:0] idx;
    begin
      case (idx)
        `HPSR_IDX_VERSION: hpsr_rd = CHIP_VERSION;
        `HPSR_IDX_TRACK:   hpsr_rd = track_ff;
        `HPSR_IDX_DFLOOR:  hpsr_rd = dfloor_ff;
        `HPSR_IDX_CCEIL:   hpsr_rd = cceil_ff;
        `HPSR_IDX_COLD:    hpsr_rd = cold_ff;
        `HPSR_IDX_HOT:     hpsr_rd = hot_ff;
        `HPSR_IDX_PWR:     hpsr_rd = pwr_ff;
        `HPSR_IDX_SLEEP:   hpsr_rd = sleep_ff;
        `HPSR_IDX_STORATE: hpsr_rd = storate_ff;
        `HPSR_IDX_PMON:    hpsr_rd = pmon_ff;
        `HPSR_IDX_INTERRUPT_ENABLES:   hpsr_rd = interrupt_enables_ff;
        `HPSR_IDX_CTRL:    hpsr_rd = {5'h00, sync_pending_in, 1'b0, update_ff};
        `HPSR_IDX_INTERRUPT_FLAGS:  hpsr_rd = {2'h0, flags_ff};
        `HPSR_IDX_STATUS:  hpsr_rd = status_in & `HPSR_MSK_STATUS;
        8'h0e:             hpsr_rd = power_data_in[7:0];
        8'h0f:             hpsr_rd = power_data_in[15:8];
        8'h10:             hpsr_rd = power_data_in[23:16];
        `HPSR_IDX_TEMPD:   hpsr_rd = temperature_in;
        `HPSR_IDX_STOD:    hpsr_rd = storage_voltage_in;
        `HPSR_IDX_SRCD:    hpsr_rd = source_voltage_in;
        default:           hpsr_rd = 8'h00;
      endcase
    end
  endfunction

  // ----------------------------------------
  // serial engine
  // ----------------------------------------
  // samples sda on scl rise, changes sda on scl fall; the 20 MHz core clock
  // oversamples a 1 MHz bus clock ten times per half period
  wire       byte_done = scl_rise && (bitcnt_ff == 4'h7);
  wire [7:0] rx_byte   = {shift_ff[6:0], sda_s};
  wire       wr_data   = (state_ff == ST_WRX) && byte_done && !first_ff;
  wire [7:0] rd_next   = hpsr_rd(index_ff);

  always @(posedge core_clk_in) begin
    if (rst_all) begin
      scl_d_ff     <= 1'b1;
      sda_d_ff     <= 1'b1;
      state_ff     <= ST_IDLE;
      shift_ff     <= 8'h00;
      bitcnt_ff    <= 4'h0;
      index_ff     <= 8'h00;
      first_ff     <= 1'b0;
      rnw_ff       <= 1'b0;
      drive_low_ff <= 1'b0;
      ack_hold_ff  <= 1'b0;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
      if (start_c) begin
        state_ff     <= ST_ADDR;
        bitcnt_ff    <= 4'h0;
        drive_low_ff <= 1'b0;
      end else if (stop_c) begin
        state_ff     <= ST_IDLE;
        drive_low_ff <= 1'b0;
      end else begin
        case (state_ff)
          ST_IDLE: begin
            drive_low_ff <= 1'b0;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              shift_ff  <= rx_byte;
              bitcnt_ff <= bitcnt_ff + 4'h1;
            end
            if (byte_done) begin
              if (rx_byte[7:1] == own_addr) begin
                rnw_ff   <= rx_byte[0];
                first_ff <= 1'b1;
                state_ff <= ST_AACK;
              end else begin
                state_ff <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            // ack bit: drive low from the falling edge after the 8th bit
            if (scl_fall && !drive_low_ff) begin
              drive_low_ff <= 1'b1;
            end else if (scl_fall && drive_low_ff) begin
              bitcnt_ff <= 4'h0;
              if (rnw_ff) begin
                shift_ff     <= rd_next;
                drive_low_ff <= !rd_next[7];
                state_ff     <= ST_RTX;
              end else begin
                drive_low_ff <= 1'b0;
                // first_ff was set by the address, so only the next byte is an index
                state_ff     <= ST_WRX;
              end
            end
          end
          ST_WRX: begin
            if (scl_rise) begin
              shift_ff  <= rx_byte;
              bitcnt_ff <= bitcnt_ff + 4'h1;
            end
            if (byte_done) begin
              if (first_ff) begin
                index_ff <= rx_byte;
              end else begin
                index_ff <= index_ff + 8'h01;
              end
              first_ff <= 1'b0;
              rnw_ff   <= 1'b0;
              state_ff <= ST_AACK;
            end
          end
          ST_RTX: begin
            if (scl_rise) begin
              bitcnt_ff <= bitcnt_ff + 4'h1;
            end
            if (scl_fall) begin
              if (bitcnt_ff == 4'h8) begin
                drive_low_ff <= 1'b0;
                index_ff     <= index_ff + 8'h01;
                state_ff     <= ST_MACK;
              end else begin
                shift_ff     <= {shift_ff[6:0], 1'b0};
                drive_low_ff <= !shift_ff[6];
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              ack_hold_ff <= sda_s;
            end
            if (scl_fall) begin
              if (ack_hold_ff) begin
                state_ff <= ST_IDLE;
              end else begin
                bitcnt_ff    <= 4'h0;
                shift_ff     <= rd_next;
                drive_low_ff <= !rd_next[7];
                state_ff     <= ST_RTX;
              end
            end
          end
          default: begin
            state_ff <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // open drain: enable low means pull low
  assign sda_out      = 1'b0;
  assign sda_oe_n_out = !drive_low_ff;

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always @(posedge core_clk_in) begin
    if (rst_all) begin
      track_ff   <= `HPSR_RST_TRACK;
      dfloor_ff  <= `HPSR_RST_DFLOOR;
      cceil_ff   <= `HPSR_RST_CCEIL;
      cold_ff    <= `HPSR_RST_COLD;
      hot_ff     <= `HPSR_RST_HOT;
      pwr_ff     <= `HPSR_RST_PWR;
      sleep_ff   <= `HPSR_RST_SLEEP;
      storate_ff <= `HPSR_RST_STORATE;
      pmon_ff    <= `HPSR_RST_PMON;
      interrupt_enables_ff   <= `HPSR_RST_INTERRUPT_ENABLES;
      update_ff  <= 1'b0;
    end else if (wr_data) begin
      case (index_ff)
        `HPSR_IDX_TRACK:   track_ff   <= rx_byte & `HPSR_MSK_TRACK;
        `HPSR_IDX_DFLOOR:  dfloor_ff  <= rx_byte & `HPSR_MSK_THRESH;
        `HPSR_IDX_CCEIL:   cceil_ff   <= rx_byte & `HPSR_MSK_THRESH;
        `HPSR_IDX_COLD:    cold_ff    <= rx_byte;
        `HPSR_IDX_HOT:     hot_ff     <= rx_byte;
        `HPSR_IDX_PWR:     pwr_ff     <= rx_byte & `HPSR_MSK_PWR;
        `HPSR_IDX_SLEEP:   sleep_ff   <= rx_byte & `HPSR_MSK_SLEEP;
        `HPSR_IDX_STORATE: storate_ff <= rx_byte & `HPSR_MSK_STORATE;
        `HPSR_IDX_PMON:    pmon_ff    <= rx_byte & `HPSR_MSK_PMON;
        `HPSR_IDX_INTERRUPT_ENABLES:   interrupt_enables_ff   <= rx_byte & `HPSR_MSK_IRQ;
        // update is sticky: once set, pins stay ignored until reset
        `HPSR_IDX_CTRL:    update_ff  <= update_ff | rx_byte[`HPSR_CTRL_UPDATE];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // flags and interrupt
  // ----------------------------------------
  // flags clear when the flag register is read out; a new event wins
  wire flg_read = (state_ff == ST_RTX) && scl_fall && (bitcnt_ff == 4'h8) &&
                  (index_ff == `HPSR_IDX_INTERRUPT_FLAGS);
  always @(posedge core_clk_in) begin
    if (rst_all) begin
      flags_ff <= 6'h00;
      irq_out  <= 1'b0;
    end else begin
      flags_ff <= (flg_read ? 6'h00 : flags_ff) | (event_in & interrupt_enables_ff[5:0]);
      // interface-ready flag is raised when leaving reset through event_in[0]
      irq_out  <= |(flags_ff & interrupt_enables_ff[5:0]) | !interrupt_enables_ff[0];
    end
  end

  // ----------------------------------------
  // effective controls
  // ----------------------------------------
  always @(posedge core_clk_in) begin
    if (rst_all) begin
      charge_enable_out       <= 1'b0;
      supply_from_storage_out <= 1'b0;
      tracking_config_out     <= `HPSR_RST_TRACK;
      discharge_floor_out     <= 6'h2d;
      charge_ceiling_out      <= 6'h33;
      power_settings_out      <= 4'h7;
      use_regs_out            <= 1'b0;
    end else begin
      use_regs_out        <= update_ff;
      tracking_config_out <= track_ff;
      discharge_floor_out <= dfloor_ff[5:0];
      charge_ceiling_out  <= cceil_ff[5:0];
      power_settings_out  <= pwr_ff[3:0];
      if (update_ff) begin
        charge_enable_out       <= !pwr_ff[`HPSR_PWR_CHGDIS];
        supply_from_storage_out <= pwr_ff[`HPSR_PWR_HOLD];
      end else begin
        charge_enable_out       <= !inh_s;
        supply_from_storage_out <= hold_s;
      end
    end
  end
endmodule

// >>> tb/hpsr_chk_sva.sv
// concurrent checks on the ports of the serial register bank
`timescale 1ns/1ps
module hpsr_chk (
  // clock and resets
  input wire       core_clk_in,
  input wire       nrst_in,
  input wire       supply_ok_in,
  // pins
  input wire       scl_in,
  input wire       sda_in,
  input wire       sda_oe_n_out,
  input wire       charge_inhibit_pin_in,
  input wire       supply_hold_pin_in,
  input wire [5:0] event_in,
  // controls
  input wire       charge_enable_out,
  input wire       supply_from_storage_out,
  input wire       irq_out,
  input wire [7:0] tracking_config_out,
  input wire [5:0] discharge_floor_out,
  input wire [5:0] charge_ceiling_out,
  input wire [3:0] power_settings_out,
  input wire       use_regs_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  wire in_rst = !nrst_in || !supply_ok_in;
  // ------------------------------------------------
  // sequences
  // ------------------------------------------------
  // data rising while the link clock stays high ends a frame
  sequence stop_s;
    scl_in && $past(scl_in) && $rose(sda_in);
  endsequence
  // six cycles covers the pin synchronisers plus the output register
  sequence pin_mode_s(p);
    (!use_regs_out && $stable(p)) [*6];
  endsequence
  property dflt_p;
    in_rst |=> tracking_config_out == 8'h77 && discharge_floor_out == 6'h2d
      && charge_ceiling_out == 6'h33 && power_settings_out == 4'h7;
  endproperty
  // ------------------------------------------------
  // assertions
  // ------------------------------------------------
  rst_quiet_a: assert property (!nrst_in |=> !irq_out && sda_oe_n_out && !charge_enable_out)
    else $error("outputs active in reset");
  supply_drop_a: assert property (!supply_ok_in |=> !irq_out && !use_regs_out && !supply_from_storage_out)
    else $error("state kept across supply loss");
  rst_dflt_a: assert property (dflt_p)
    else $error("config outputs not at defaults after reset");
  inhibit_pin_a: assert property (disable iff (in_rst)
    pin_mode_s(charge_inhibit_pin_in) |-> charge_enable_out != charge_inhibit_pin_in)
    else $error("charge enable does not follow inhibit pin");
  hold_pin_a: assert property (disable iff (in_rst)
    pin_mode_s(supply_hold_pin_in) |-> supply_from_storage_out == supply_hold_pin_in)
    else $error("supply source does not follow hold pin");
  regs_mode_a: assert property (disable iff (in_rst) (use_regs_out && $stable(power_settings_out)) [*3]
    |-> charge_enable_out == !power_settings_out[3] && supply_from_storage_out == power_settings_out[0])
    else $error("register mode controls wrong");
  pins_ignored_a: assert property (disable iff (in_rst)
    use_regs_out && $changed(supply_hold_pin_in) |=> $stable(supply_from_storage_out) [*4])
    else $error("pin acted after update");
  stop_idle_a: assert property (disable iff (in_rst) stop_s |=> sda_oe_n_out [*8])
    else $error("data driven after stop");
  event_irq_a: assert property (disable iff (in_rst) event_in[0] |-> ##[1:4] irq_out)
    else $error("ready event gave no interrupt");
endmodule

// >>> tb/hpsr_bus_master.sv
// two-wire bus master model that paces the link clock from the core clock
`timescale 1ns/1ps
module hpsr_bus_master (
  // pacing clock
  input  wire core_clk_in,
  // wire level of the data line
  input  wire sda_in,
  // open-drain drives, high means released
  output reg  scl_out,
  output reg  sda_rel_out
);
  initial begin
    scl_out = 1'b1;
    sda_rel_out = 1'b1;
  end
  // quarter of the 400 ns link period; link clock stands high outside frames
  task q;
    repeat (2) @(posedge core_clk_in);
    #1;
  endtask
  // also serves as repeated start when the clock is low
  task start;
    q;
    sda_rel_out = 1'b1;
    q;
    scl_out = 1'b1;
    q;
    sda_rel_out = 1'b0;
    q;
    scl_out = 1'b0;
  endtask
  task stop;
    q;
    sda_rel_out = 1'b0;
    q;
    scl_out = 1'b1;
    q;
    sda_rel_out = 1'b1;
    q;
  endtask
  // data only moves while the clock is low, sampled at the end of high
  task bitx(input b, output r);
    q;
    sda_rel_out = b;
    q;
    scl_out = 1'b1;
    q;
    q;
    r = sda_in;
    scl_out = 1'b0;
  endtask
  task wbyte(input [7:0] b, output ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'b1, ack);
  endtask
  task rbyte(input last, output [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, b[i]);
    bitx(last, r);
  endtask
endmodule

// >>> tb/tb_top.sv
// self-checking bench for the serial register bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top;
  // ------------------------------------------------
  // nets
  // ------------------------------------------------
  localparam [7:0] VER = 8'h10;  // arbitrary version value
  logic        core_clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        supply_ok_in = 1'b1;
  logic        addr_sel_in = 1'b1;
  logic        charge_inhibit_pin_in = 1'b0;
  logic        supply_hold_pin_in = 1'b0;
  logic [5:0]  event_in = 6'h00;
  logic [7:0]  status_in = 8'hff;
  logic        sync_pending_in = 1'b1;
  logic [23:0] power_data_in = 24'h000000;
  logic [7:0]  temperature_in = 8'h00;
  logic [7:0]  storage_voltage_in = 8'h00;
  logic [7:0]  source_voltage_in = 8'h00;
  wire         scl_in;
  wire         m_sda;
  wire         sda_out;
  wire         sda_oe_n_out;
  wire         sda_in = m_sda & (sda_oe_n_out | sda_out);
  wire         charge_enable_out;
  wire         supply_from_storage_out;
  wire         irq_out;
  wire [7:0]   tracking_config_out;
  wire [5:0]   discharge_floor_out;
  wire [5:0]   charge_ceiling_out;
  wire [3:0]   power_settings_out;
  wire         use_regs_out;
  int          num_errors = 0;
  int          n_checks = 0;
  logic [7:0]  wd [0:2];
  logic [7:0]  rb [0:11];
  logic [7:0]  ex [$];
  logic        ak;

  always #25 core_clk_in = ~core_clk_in;

  hpsr_serial_regs #(.CHIP_VERSION(VER)) uut (.*);
  hpsr_bus_master bm (.core_clk_in(core_clk_in), .sda_in(sda_in), .scl_out(scl_in), .sda_rel_out(m_sda));

  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task step(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  task wait_irq(input v);
    int t;
    t = 0;
    while (irq_out !== v && t < 50) begin
      step(1);
      t++;
    end
    `CHK("irq", v, irq_out)
    if (irq_out !== v) complete_run();
  endtask
  // index write, nw data bytes, then optional repeated-start read of nr bytes
  task xfer(input [6:0] a, input [7:0] i, input int nw, input int nr);
    bm.start();
    bm.wbyte({a, 1'b0}, ak);
    `CHK("addr ack", 1'b0, ak)
    bm.wbyte(i, ak);
    `CHK("index ack", 1'b0, ak)
    for (int k = 0; k < nw; k++) begin
      bm.wbyte(wd[k], ak);
      `CHK("data ack", 1'b0, ak)
    end
    if (nr > 0) begin
      bm.start();
      bm.wbyte({a, 1'b1}, ak);
      `CHK("read addr ack", 1'b0, ak)
      for (int k = 0; k < nr; k++) bm.rbyte(k == nr - 1, rb[k]);
    end
    bm.stop();
  endtask
  task cmp;
    foreach (ex[k]) `CHK("read byte", ex[k], rb[k])
  endtask
  task complete_run;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ------------------------------------------------
  // sequence
  // ------------------------------------------------
  initial begin
    repeat (6) @(posedge core_clk_in);
    #1;
    `CHK("irq in reset", 1'b0, irq_out)
    `CHK("tracking reset", 8'h77, tracking_config_out)
    `CHK("floor reset", 6'h2d, discharge_floor_out)
    `CHK("ceiling reset", 6'h33, charge_ceiling_out)
    `CHK("power reset", 4'h7, power_settings_out)
    nrst_in = 1'b1;
    step(4);
    event_in = 6'h01;
    step(1);
    event_in = 6'h00;
    wait_irq(1'b1);
    xfer(7'h41, 8'h00, 0, 12);
    ex = '{VER, 8'h77, 8'h2d, 8'h33, 8'h8f, 8'h2f, 8'h07, 8'h01, 8'h00, 8'h00, 8'h01, 8'h04};
    cmp();
    xfer(7'h41, 8'h0c, 0, 1);
    ex = '{8'h01};
    cmp();
    xfer(7'h41, 8'h0c, 0, 1);
    ex = '{8'h00};
    cmp();
    wait_irq(1'b0);
    wd = '{8'hff, 8'h2a, 8'h00};
    xfer(7'h41, 8'h02, 2, 0);
    xfer(7'h41, 8'h02, 0, 2);
    ex = '{8'h3f, 8'h2a};
    cmp();
    `CHK("floor out", 6'h3f, discharge_floor_out)
    `CHK("ceiling out", 6'h2a, charge_ceiling_out)
    power_data_in = 24'h123456;
    temperature_in = 8'h5a;
    storage_voltage_in = 8'ha5;
    source_voltage_in = 8'h3c;
    xfer(7'h41, 8'h0d, 3, 0);
    xfer(7'h41, 8'h0d, 0, 8);
    ex = '{8'h5e, 8'h56, 8'h34, 8'h12, 8'h5a, 8'ha5, 8'h3c, 8'h00};
    cmp();
    addr_sel_in = 1'b0;
    step(4);
    xfer(7'h40, 8'h05, 0, 1);
    ex = '{8'h2f};
    cmp();
    bm.start();
    bm.wbyte({7'h41, 1'b0}, ak);
    `CHK("foreign nack", 1'b1, ak)
    bm.stop();
    addr_sel_in = 1'b1;
    charge_inhibit_pin_in = 1'b1;
    supply_hold_pin_in = 1'b1;
    step(6);
    `CHK("charge off", 1'b0, charge_enable_out)
    `CHK("hold supply", 1'b1, supply_from_storage_out)
    charge_inhibit_pin_in = 1'b0;
    supply_hold_pin_in = 1'b0;
    step(6);
    `CHK("charge on", 1'b1, charge_enable_out)
    `CHK("no hold", 1'b0, supply_from_storage_out)
    wd = '{8'h08, 8'h00, 8'h00};
    xfer(7'h41, 8'h06, 1, 0);
    wd = '{8'h01, 8'h00, 8'h00};
    xfer(7'h41, 8'h0b, 1, 0);
    step(4);
    `CHK("update", 1'b1, use_regs_out)
    `CHK("charge reg", 1'b0, charge_enable_out)
    `CHK("power out", 4'h8, power_settings_out)
    supply_hold_pin_in = 1'b1;
    step(6);
    `CHK("hold ignored", 1'b0, supply_from_storage_out)
    supply_ok_in = 1'b0;
    step(4);
    supply_ok_in = 1'b1;
    step(4);
    `CHK("update lost", 1'b0, use_regs_out)
    `CHK("power lost", 4'h7, power_settings_out)
    complete_run();
  end
endmodule

bind hpsr_serial_regs hpsr_chk chk (.*);
